// ---- hdl/angc_regs.svh ----
`ifndef ANGC_REGS_SVH
`define ANGC_REGS_SVH

`define ANGC_ADDR_W 5
`define ANGC_DATA_W 16
`define ANGC_CODE_W 11
`define ANGC_OFS_PAGE_RX 5'h08
`define ANGC_OFS_GIG_CFG 5'h09

`define ANGC_BIT_MORE 15
`define ANGC_BIT_ACK 14
`define ANGC_BIT_MSG 13
`define ANGC_BIT_COMPLY 12
`define ANGC_BIT_TOG 11
`define ANGC_BIT_TEST_HI 15
`define ANGC_BIT_TEST_LO 13
`define ANGC_BIT_MAN_EN 12
`define ANGC_BIT_MAN_VAL 11
`define ANGC_BIT_MULTI 10
`define ANGC_BIT_FD 9
`define ANGC_BIT_HD 8
`define ANGC_BIT_AUTO_TDR 7

`define ANGC_PAGE_RST 16'h2001
`define ANGC_CFG_RST 16'h0300
`define ANGC_PAGE_WR_MASK 16'hB7FF
`define ANGC_CFG_WR_MASK 16'hFF80

`endif

// ---- hdl/angc_pkg.sv ----
`include "angc_regs.svh"

package angc_pkg;

  typedef enum logic [2:0] {
    ANGC_TEST_NORMAL = 3'b000,
    ANGC_TEST_WAVEFORM = 3'b001,
    ANGC_TEST_JITTER_MASTER = 3'b010,
    ANGC_TEST_JITTER_SLAVE = 3'b011,
    ANGC_TEST_DISTORTION = 3'b100,
    ANGC_TEST_MLT3_IDLE = 3'b101,
    ANGC_TEST_REPEAT_0001 = 3'b110,
    ANGC_TEST_PULSE_ZEROS = 3'b111
  } angc_test_mode_e;

  typedef struct packed {
    logic moreP;
    logic ack;
    logic msgPage;
    logic comply;
    logic toggle;
    logic [`ANGC_CODE_W-1:0] code;
  } angc_page_s;

  typedef struct packed {
    angc_test_mode_e testMode;
    logic manEn;
    logic manVal;
    logic multiPort;
    logic fdAdv;
    logic hdAdv;
    logic autoTdr;
    logic [6:0] rsvd;
  } angc_cfg_s;

  typedef struct packed {
    logic [`ANGC_ADDR_W-1:0] addr;
    logic [`ANGC_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } angc_bus_s;

  typedef struct packed {
    logic manual;
    logic master;
  } angc_ms_s;

  typedef struct packed {
    angc_page_s page;
    angc_cfg_s cfg;
    logic [`ANGC_DATA_W-1:0] rdData;
    logic strapDone;
  } angc_top_state_s;

  typedef struct packed {
    logic linkPrev;
    logic tdrStart;
    angc_ms_s ms;
    angc_test_mode_e testMode;
  } angc_dec_state_s;

endpackage

// ---- hdl/angc_cfg_decode.sv ----
`timescale 1ns/1ps
`include "angc_regs.svh"

module angc_cfg_decode
  import angc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input angc_cfg_s cfg,
  input wire logic linkUp,
  input wire logic autoMaster,
  output angc_ms_s msCtl,
  output logic tdrStart,
  output angc_test_mode_e testMode
);

  angc_dec_state_s st;
  angc_dec_state_s next_st;
  logic linkDown;

  assign linkDown = st.linkPrev & ~linkUp;

  always_comb begin
    next_st = st;
    next_st.linkPrev = linkUp;
    next_st.tdrStart = linkDown & cfg.autoTdr;
    next_st.ms.manual = cfg.manEn;
    // automatic resolution stays in charge unless software takes over
    next_st.ms.master = cfg.manEn ? cfg.manVal : autoMaster;
    next_st.testMode = cfg.testMode;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign msCtl = st.ms;
  assign tdrStart = st.tdrStart;
  assign testMode = st.testMode;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  tdr_launch_a: assert property (linkDown && cfg.autoTdr |=> tdrStart)
    else $error("link down with auto diagnostic did not launch it");
  tdr_quiet_a: assert property (!cfg.autoTdr |=> !tdrStart)
    else $error("diagnostic launched while auto run disabled");
  ms_manual_a: assert property (cfg.manEn |=> msCtl.manual && msCtl.master == $past(cfg.manVal))
    else $error("manual master/slave value not applied");
  // flops still hold reset at the release edge, so skip the attempt started there
  ms_auto_a: assert property (!cfg.manEn && $past(arst_n) |=> !msCtl.manual && msCtl.master == $past(autoMaster))
    else $error("automatic resolution not used when manual disabled");

  tdr_run_c: cover property (linkDown && cfg.autoTdr ##1 tdrStart);

endmodule

// ---- hdl/angc_regs_top.sv ----
`timescale 1ns/1ps
`include "angc_regs.svh"

module angc_regs_top
  import angc_pkg::*;
#(
  parameter bit FD_FROM_STRAP = 1'b0
)
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input angc_bus_s bus,
  output logic [`ANGC_DATA_W-1:0] rdData,
  input angc_page_s rxWord,
  input wire logic rxWordValid,
  input wire logic strapFdAdv,
  input wire logic linkUp,
  input wire logic autoMaster,
  output angc_page_s partnerPage,
  output angc_cfg_s gigCfg,
  output angc_ms_s msCtl,
  output logic tdrStart,
  output angc_test_mode_e testMode
);

  angc_top_state_s st;
  angc_top_state_s next_st;
  logic wrPage;
  logic wrCfg;
  logic rdPage;
  logic rdCfg;
  logic [`ANGC_DATA_W-1:0] pageWord;
  logic [`ANGC_DATA_W-1:0] cfgWord;
  logic [`ANGC_DATA_W-1:0] pageMask;
  logic [`ANGC_DATA_W-1:0] cfgMask;

  assign wrPage = bus.wr && (bus.addr == `ANGC_OFS_PAGE_RX);
  assign wrCfg = bus.wr && (bus.addr == `ANGC_OFS_GIG_CFG);
  assign rdPage = bus.rd && (bus.addr == `ANGC_OFS_PAGE_RX);
  assign rdCfg = bus.rd && (bus.addr == `ANGC_OFS_GIG_CFG);
  assign pageWord = st.page;
  assign cfgWord = st.cfg;
  assign pageMask = `ANGC_PAGE_WR_MASK;
  assign cfgMask = `ANGC_CFG_WR_MASK;

  always_comb begin
    next_st = st;
    next_st.rdData = '0;

    // strap sampled one cycle after release, never inside the reset branch
    if (!st.strapDone) begin
      next_st.strapDone = 1'b1;
      if (FD_FROM_STRAP) begin
        next_st.cfg.fdAdv = strapFdAdv;
      end
    end

    // software may edit the writable fields of the received page
    if (wrPage) begin
      next_st.page = angc_page_s'((pageWord & ~pageMask) | (bus.wdata & pageMask));
    end

    // a page from the arbitration engine wins over a same-cycle write
    if (rxWordValid) begin
      next_st.page.moreP = rxWord.moreP;
      next_st.page.ack = rxWord.ack;
      next_st.page.msgPage = rxWord.msgPage;
      next_st.page.comply = rxWord.comply;
      next_st.page.toggle = ~rxWord.toggle;
      // code is raw; consumers read msgPage to pick message or unformatted meaning
      next_st.page.code = rxWord.code;
    end

    if (wrCfg) begin
      // reserved bits stay zero since the mask never covers them
      next_st.cfg = angc_cfg_s'((cfgWord & ~cfgMask) | (bus.wdata & cfgMask));
    end

    if (rdPage) begin
      next_st.rdData = pageWord;
    end else if (rdCfg) begin
      next_st.rdData = cfgWord;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st.page <= angc_page_s'(`ANGC_PAGE_RST);
      // fdAdv resets set; strapped builds overwrite it right after release
      st.cfg <= angc_cfg_s'(`ANGC_CFG_RST);
      st.rdData <= '0;
      st.strapDone <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign rdData = st.rdData;
  assign partnerPage = st.page;
  assign gigCfg = st.cfg;

  angc_cfg_decode u_decode (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .cfg(st.cfg),
    .linkUp(linkUp),
    .autoMaster(autoMaster),
    .msCtl(msCtl),
    .tdrStart(tdrStart),
    .testMode(testMode)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  page_read_a: assert property (rdPage |=> rdData == $past(pageWord))
    else $error("page read returned wrong data");
  cfg_read_a: assert property (rdCfg |=> rdData == $past(cfgWord))
    else $error("config read returned wrong data");
  idle_read_a: assert property (!(rdPage || rdCfg) |=> rdData == '0)
    else $error("read data not zero outside read answer");
  cfg_rsvd_a: assert property (gigCfg.rsvd == 7'h00)
    else $error("config reserved bits not zero");
  ack_ro_a: assert property (!rxWordValid |=> partnerPage.ack == $past(partnerPage.ack))
    else $error("acknowledge bit changed without a received page");
  tog_ro_a: assert property (!rxWordValid |=> partnerPage.toggle == $past(partnerPage.toggle))
    else $error("toggle bit changed without a received page");
  tog_inv_a: assert property (rxWordValid |=> partnerPage.toggle == !$past(rxWord.toggle))
    else $error("toggle bit not inverse of received toggle");
  page_load_a: assert property (rxWordValid |=> partnerPage.moreP == $past(rxWord.moreP)
      && partnerPage.msgPage == $past(rxWord.msgPage) && partnerPage.comply == $past(rxWord.comply)
      && partnerPage.code == $past(rxWord.code))
    else $error("received page fields not captured");
  cfg_write_a: assert property (wrCfg |=> cfgWord[15:7] == $past(bus.wdata[15:7]))
    else $error("config write not stored");
  cfg_hold_a: assert property (!wrCfg && st.strapDone |=> cfgWord == $past(cfgWord))
    else $error("config changed without a write");
  page_write_a: assert property (wrPage && !rxWordValid |=>
      partnerPage.code == $past(bus.wdata[10:0]) && partnerPage.msgPage == $past(bus.wdata[13]))
    else $error("page writable fields not stored");

  page_rx_c: cover property (rxWordValid ##1 rdPage);
  wr_rd_c: cover property (wrCfg ##2 rdCfg);
  clash_c: cover property (wrPage && rxWordValid);

endmodule

// ---- verification/angc_link_partner.sv ----
`timescale 1ns/1ps
module angc_link_partner
  import angc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sendReq,
  input angc_page_s sendWord,
  input wire logic dropLink,
  output angc_page_s rxWord,
  output logic rxWordValid,
  output logic linkUp,
  output logic autoMaster
);
  initial begin
    rxWord = '0;
    rxWordValid = 1'b0;
    linkUp = 1'b0;
    autoMaster = 1'b0;
  end
  always @(posedge sys_clk) begin
    rxWordValid <= sendReq;
    // stale word inverted so a missed strobe never looks right
    rxWord <= sendReq ? sendWord : ~rxWord;
    linkUp <= !dropLink;
    // partner only resolves automatically, never a clashing forced role
    autoMaster <= ~autoMaster;
  end
endmodule

// ---- verification/angc_regs_top_tb_top.sv ----
`timescale 1ns/1ps
module angc_regs_top_tb_top
  import angc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  angc_bus_s bus = '0;
  logic [15:0] rdData;
  angc_page_s rxWord;
  angc_page_s partnerPage;
  angc_page_s sendWord = '0;
  logic rxWordValid;
  logic linkUp;
  logic autoMaster;
  logic tdrStart;
  logic sendReq = 1'b0;
  logic dropLink = 1'b1;
  logic strapFdAdv = 1'b0;
  angc_cfg_s gigCfg;
  angc_cfg_s gigCfgStrap;
  angc_ms_s msCtl;
  angc_test_mode_e testMode;
  integer seed = 32'h4A0FE118;
  integer err_total = 0;
  integer checked = 0;
  integer cyc = 0;
  integer i;
  integer tdrSeen;
  logic [15:0] pg = 16'h2001;
  logic [15:0] cf = 16'h0300;
  logic [15:0] d;
  logic [4:0] a;

  always #25 sys_clk = ~sys_clk;

  angc_regs_top u_angc_regs_top (.sys_clk(sys_clk), .arst_n(arst_n), .bus(bus), .rdData(rdData),
    .rxWord(rxWord), .rxWordValid(rxWordValid), .strapFdAdv(strapFdAdv), .linkUp(linkUp),
    .autoMaster(autoMaster), .partnerPage(partnerPage), .gigCfg(gigCfg), .msCtl(msCtl),
    .tdrStart(tdrStart), .testMode(testMode));

  // strapped build: full-duplex advert comes from the strap pin after release
  angc_regs_top #(.FD_FROM_STRAP(1'b1)) u_angc_regs_top_strap (.sys_clk(sys_clk), .arst_n(arst_n), .bus(bus),
    .rdData(), .rxWord(rxWord), .rxWordValid(rxWordValid), .strapFdAdv(strapFdAdv), .linkUp(linkUp),
    .autoMaster(autoMaster), .partnerPage(), .gigCfg(gigCfgStrap), .msCtl(), .tdrStart(), .testMode());

  angc_link_partner u_angc_link_partner (.sys_clk(sys_clk), .sendReq(sendReq), .sendWord(sendWord),
    .dropLink(dropLink), .rxWord(rxWord), .rxWordValid(rxWordValid), .linkUp(linkUp),
    .autoMaster(autoMaster));

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrReg(input logic [4:0] ad, input logic [15:0] dt);
    @(posedge sys_clk);
    bus <= '{addr: ad, wdata: dt, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rdChk(input logic [4:0] ad, input logic [15:0] exp);
    @(posedge sys_clk);
    bus <= '{addr: ad, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    chk("rdData", exp, rdData);
  endtask

  task automatic send(input angc_page_s w);
    @(posedge sys_clk);
    sendWord <= w;
    sendReq <= 1'b1;
    @(posedge sys_clk);
    sendReq <= 1'b0;
    pg = {w.moreP, w.ack, w.msgPage, w.comply, ~w.toggle, w.code};
  endtask

  function automatic logic [15:0] expOf(input logic [4:0] ad);
    return ad == 5'h08 ? pg : (ad == 5'h09 ? cf : 16'h0000);
  endfunction

  task test_done;
    $display("mismatches %0d of %0d checks", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      test_done;
    end
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rdChk(5'h08, 16'h2001);
    rdChk(5'h09, 16'h0300);
    chk("strapCfg", 16'h0100, gigCfgStrap);
    for (i = 0; i < 48; i++) begin
      a = (i < 8) ? 5'h09 : (i % 3 == 2) ? {1'b1, 4'($random(seed))} : 5'(8 + i % 2);
      d = 16'($random(seed));
      if (i < 8) d[15:13] = i[2:0];
      wrReg(a, d);
      if (a == 5'h08) pg = (pg & 16'h4800) | (d & 16'hB7FF);
      if (a == 5'h09) cf = d & 16'hFF80;
      rdChk(a, expOf(a));
      chk("gigCfg", cf, gigCfg);
      chk("testMode", {13'h0000, cf[15:13]}, {13'h0000, testMode});
      chk("msCtl", {14'h0000, cf[12], cf[12] ? cf[11] : ~autoMaster}, {14'h0000, msCtl});
      if (i % 4 == 3) begin
        send(angc_page_s'(16'($random(seed))));
        rdChk(5'h08, pg);
        chk("partnerPage", pg, partnerPage);
      end
    end
    // corner: received page and software write land on the same edge
    fork
      send(angc_page_s'(16'($random(seed))));
      begin
        @(posedge sys_clk);
        wrReg(5'h08, 16'hFFFF);
      end
    join
    rdChk(5'h08, pg);
    for (i = 0; i < 2; i++) begin
      cf = i ? 16'h0080 : 16'h0000;
      wrReg(5'h09, cf);
      dropLink <= 1'b0;
      repeat (4) @(posedge sys_clk);
      dropLink <= 1'b1;
      tdrSeen = 0;
      repeat (6) begin
        @(posedge sys_clk);
        #1;
        tdrSeen += tdrStart;
      end
      chk("tdrPulses", 16'(i), 16'(tdrSeen));
    end
    test_done;
  end
endmodule
